//--- verilog/sra_device.sv
`timescale 1ns/100ps
`default_nettype none

// Operation
// - Traffic counts only while select is low.
// - Sample serial input on rising clock.
// - Works at any serial clock rate well below the system clock, even stopped.
// - Frame is 24 bits, MSB first.
// - First bit one reads, zero writes.
// - Next fifteen bits are the address.
// - Write frame stores last eight bits.
// - Read frame ignores input, shifts register out.
// - Output driven only in read data phase.
// - Wide registers are little-endian.
// - Further bytes stream while select stays low.
// - Address steps up, or down if cleared.
// - Address hold stops streaming address stepping.
// - Host starts no access during calibration; the host only holds off starting one, and a frame already running goes on.
module sra_device
    import sra_pkg::*;
#(
    // Identity values are arbitrary.
    parameter logic [7:0]  PART_CLASS_VAL  = 8'h5A,
    parameter logic [15:0] PART_ID_VAL     = 16'h1234,
    parameter logic [7:0]  SILICON_REV_VAL = 8'h01,
    parameter logic [15:0] MAKER_ID_VAL    = 16'hBEEF
) (
    input  wire logic       CLK_SYS,
    input  wire logic       RESET,
    sra_if.device           LINK,
    output var  logic [7:0] OPERATING_SETUP,
    output var  logic [7:0] INTERFACE_SETUP,
    output var  logic       ACCESS_ACTIVE
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_HEAD = 2'b01,
        ST_DATA = 2'b11
    } state_e;

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] pin_raw;
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic       sclk_prev_q;

    // Flops start at the idle pin levels, so no false edge follows reset.
    localparam logic [2:0] PIN_IDLE = 3'h2;

    assign pin_raw = {LINK.sclk, LINK.select_n, LINK.serial_in};

    for (genvar i = 0; i < 3; i++) begin : g_sync
        always_ff @(posedge CLK_SYS or posedge RESET) begin
            if (RESET) begin
                meta_q[i] <= PIN_IDLE[i];
                sync_q[i] <= PIN_IDLE[i];
            end else begin
                meta_q[i] <= pin_raw[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= sync_q[2];
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic selected;
    logic si;

    // Edges come from the sampled clock, so any rate down to a halt works.
    assign sclk_rise = sync_q[2] & ~sclk_prev_q;
    assign sclk_fall = ~sync_q[2] & sclk_prev_q;
    assign selected  = ~sync_q[1];
    assign si        = sync_q[0];

    // ------------------------------------------------------------------
    // Register read decode
    // ------------------------------------------------------------------
    logic [7:0] ia_q;
    logic [7:0] ia_d;
    logic [7:0] os_q;
    logic [7:0] os_d;
    logic [7:0] ui_q;
    logic [7:0] ui_d;

    function automatic logic [7:0] read_reg(input logic [14:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADR_IFACE_SETUP_A: v = ia_q;
            ADR_OPER_SETUP:    v = os_q;
            ADR_PART_CLASS:    v = PART_CLASS_VAL;
            ADR_PART_ID_LO:    v = PART_ID_VAL[7:0];
            ADR_PART_ID_HI:    v = PART_ID_VAL[15:8];
            ADR_SILICON_REV:   v = SILICON_REV_VAL;
            ADR_MAKER_ID_LO:   v = MAKER_ID_VAL[7:0];
            ADR_MAKER_ID_HI:   v = MAKER_ID_VAL[15:8];
            ADR_USER_SETUP:    v = ui_q;
            default:           v = 8'h00;
        endcase
        return v;
    endfunction : read_reg

    // ------------------------------------------------------------------
    // Frame engine
    // ------------------------------------------------------------------
    state_e      st_q;
    state_e      st_d;
    logic [3:0]  cnt_q;
    logic [3:0]  cnt_d;
    logic [15:0] hdr_q;
    logic [15:0] hdr_d;
    logic        rd_q;
    logic        rd_d;
    logic [14:0] addr_q;
    logic [14:0] addr_d;
    logic [7:0]  din_q;
    logic [7:0]  din_d;
    logic [7:0]  dout_q;
    logic [7:0]  dout_d;
    logic        so_q;
    logic        so_d;
    logic        oe_q;
    logic        oe_d;

    always_comb begin
        logic [14:0] next_a;
        logic [7:0]  byte_in;
        next_a  = 15'h0000;
        byte_in = {din_q[6:0], si};
        st_d    = st_q;
        cnt_d   = cnt_q;
        hdr_d   = hdr_q;
        rd_d    = rd_q;
        addr_d  = addr_q;
        din_d   = din_q;
        dout_d  = dout_q;
        so_d    = so_q;
        oe_d    = oe_q;
        ia_d    = ia_q;
        os_d    = os_q;
        ui_d    = ui_q;
        if (!selected) begin
            // Releasing select mid-frame drops it with no write.
            st_d  = ST_IDLE;
            cnt_d = 4'h0;
            oe_d  = 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    st_d  = ST_HEAD;
                    cnt_d = 4'h0;
                end
                ST_HEAD: begin
                    if (sclk_rise) begin
                        hdr_d = {hdr_q[14:0], si};
                        cnt_d = cnt_q + 4'h1;
                        if ({1'b0, cnt_q} == HEAD_LAST) begin
                            rd_d   = hdr_q[14];
                            addr_d = {hdr_q[13:0], si};
                            dout_d = read_reg({hdr_q[13:0], si});
                            cnt_d  = 4'h0;
                            st_d   = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (sclk_rise) begin
                        din_d = byte_in;
                        cnt_d = cnt_q + 4'h1;
                        if (cnt_q == BIT_LAST) begin
                            cnt_d = 4'h0;
                            if (!rd_q) begin
                                unique case (addr_q)
                                    ADR_IFACE_SETUP_A: ia_d = byte_in;
                                    ADR_OPER_SETUP:    os_d = byte_in;
                                    ADR_USER_SETUP:    ui_d = byte_in;
                                    default:           ;
                                endcase
                            end
                            if (ui_q[BIT_ADDR_HOLD]) begin
                                next_a = addr_q;
                            end else if (ia_q[BIT_ADDR_ASCEND]) begin
                                next_a = addr_q + ADR_STEP;
                            end else begin
                                next_a = addr_q - ADR_STEP;
                            end
                            addr_d = next_a;
                            dout_d = read_reg(next_a);
                        end
                    end else if (sclk_fall && rd_q) begin
                        so_d   = dout_q[7];
                        dout_d = {dout_q[6:0], 1'b0};
                        oe_d   = 1'b1;
                    end
                end
                default: st_d = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            st_q   <= ST_IDLE;
            cnt_q  <= 4'h0;
            hdr_q  <= 16'h0000;
            rd_q   <= 1'b0;
            addr_q <= 15'h0000;
            din_q  <= 8'h00;
            dout_q <= 8'h00;
            so_q   <= 1'b0;
            oe_q   <= 1'b0;
            ia_q   <= RST_IFACE_SETUP_A;
            os_q   <= RST_OPER_SETUP;
            ui_q   <= RST_USER_SETUP;
        end else begin
            st_q   <= st_d;
            cnt_q  <= cnt_d;
            hdr_q  <= hdr_d;
            rd_q   <= rd_d;
            addr_q <= addr_d;
            din_q  <= din_d;
            dout_q <= dout_d;
            so_q   <= so_d;
            oe_q   <= oe_d;
            ia_q   <= ia_d;
            os_q   <= os_d;
            ui_q   <= ui_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    logic act_q;

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            act_q <= 1'b0;
        end else begin
            act_q <= selected;
        end
    end

    assign LINK.serial_out    = so_q;
    assign LINK.serial_out_oe = oe_q;
    assign OPERATING_SETUP    = os_q;
    assign INTERFACE_SETUP    = ia_q;
    assign ACCESS_ACTIVE      = act_q;

endmodule : sra_device

`default_nettype wire

//--- shared/sra_pkg.sv
package sra_pkg;

    // ------------------------------------------------------------------
    // Frame layout
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 15;
    localparam int          HEAD_W          = 16;
    localparam logic [4:0]  HEAD_LAST       = 5'h0F;
    localparam logic [4:0]  DATA_FIRST      = 5'h10;
    localparam logic [2:0]  BYTE_LAST       = 3'h7;
    localparam logic [3:0]  BIT_LAST        = 4'h7;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [14:0] ADR_IFACE_SETUP_A = 15'h0000;
    localparam logic [14:0] ADR_OPER_SETUP    = 15'h0002;
    localparam logic [14:0] ADR_PART_CLASS    = 15'h0003;
    localparam logic [14:0] ADR_PART_ID_LO    = 15'h0004;
    localparam logic [14:0] ADR_PART_ID_HI    = 15'h0005;
    localparam logic [14:0] ADR_SILICON_REV   = 15'h0006;
    localparam logic [14:0] ADR_MAKER_ID_LO   = 15'h000C;
    localparam logic [14:0] ADR_MAKER_ID_HI   = 15'h000D;
    localparam logic [14:0] ADR_USER_SETUP    = 15'h0010;
    localparam logic [14:0] ADR_STEP          = 15'h0001;

    // ------------------------------------------------------------------
    // Reset values and fields
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_IFACE_SETUP_A = 8'h30;
    localparam logic [7:0]  RST_OPER_SETUP    = 8'h00;
    localparam logic [7:0]  RST_USER_SETUP    = 8'h00;
    localparam int          BIT_ADDR_ASCEND   = 5;
    localparam int          BIT_ADDR_ASCEND_M = 2;
    localparam int          BIT_ADDR_HOLD     = 0;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int          CLK_PERIOD_NS   = 40;
    localparam int          SCLK_HALF_NS    = 320;
    localparam int          HALF_CYCLES     = SCLK_HALF_NS / CLK_PERIOD_NS;
    localparam logic [3:0]  HALF_LAST       = 4'(HALF_CYCLES - 1);

endpackage : sra_pkg

//--- shared/sra_if.sv
`timescale 1ns/100ps
`default_nettype none

interface sra_if;
    logic sclk;
    logic select_n;
    logic serial_in;
    logic serial_out;
    logic serial_out_oe;
    logic serial_out_line;

    // The undriven output line floats high through a pull-up.
    assign serial_out_line = serial_out_oe ? serial_out : 1'b1;

    modport device (
        input  sclk,
        input  select_n,
        input  serial_in,
        output serial_out,
        output serial_out_oe
    );

    modport host (
        output sclk,
        output select_n,
        output serial_in,
        input  serial_out_line
    );
endinterface : sra_if

`default_nettype wire

//--- verilog/sra_host.sv
`timescale 1ns/100ps
`default_nettype none

module sra_host
    import sra_pkg::*;
(
    input  wire logic        CLK_SYS,
    input  wire logic        RESET,
    sra_if.host              LINK,
    input  wire logic        START,
    input  wire logic        READ,
    input  wire logic [14:0] ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic [7:0]  BYTES,
    input  wire logic        CAL_BUSY,
    output var  logic        BUSY,
    output var  logic        WDATA_TAKEN,
    output var  logic [7:0]  RDATA,
    output var  logic        RDATA_VALID
);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN  = 2'b01,
        ST_STOP = 2'b11,
        ST_GAP  = 2'b10
    } state_e;

    // ------------------------------------------------------------------
    // Returned data synchroniser
    // ------------------------------------------------------------------
    logic meta_q;
    logic so_s_q;

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            meta_q  <= 1'b1;
            so_s_q  <= 1'b1;
        end else begin
            meta_q  <= LINK.serial_out_line;
            so_s_q  <= meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------------
    state_e      st_q;
    state_e      st_d;
    logic [3:0]  div_q;
    logic [3:0]  div_d;
    logic [4:0]  cnt_q;
    logic [4:0]  cnt_d;
    logic [15:0] hdr_q;
    logic [15:0] hdr_d;
    logic [7:0]  db_q;
    logic [7:0]  db_d;
    logic [7:0]  rx_q;
    logic [7:0]  rx_d;
    logic [7:0]  left_q;
    logic [7:0]  left_d;
    logic        sclk_q;
    logic        sclk_d;
    logic        sel_n_q;
    logic        sel_n_d;
    logic        si_q;
    logic        si_d;
    logic        read_q;
    logic        read_d;
    logic        take_q;
    logic        take_d;
    logic        rdv_q;
    logic        rdv_d;
    logic [7:0]  rdata_q;
    logic [7:0]  rdata_d;

    always_comb begin
        logic tick;
        tick    = (div_q == HALF_LAST);
        st_d    = st_q;
        div_d   = tick ? 4'h0 : div_q + 4'h1;
        cnt_d   = cnt_q;
        hdr_d   = hdr_q;
        db_d    = db_q;
        rx_d    = rx_q;
        left_d  = left_q;
        sclk_d  = sclk_q;
        sel_n_d = sel_n_q;
        si_d    = si_q;
        read_d  = read_q;
        take_d  = 1'b0;
        rdv_d   = 1'b0;
        rdata_d = rdata_q;
        unique case (st_q)
            ST_IDLE: begin
                div_d = 4'h0;
                // No access is started while calibration runs.
                if (START && !CAL_BUSY) begin
                    st_d    = ST_RUN;
                    sel_n_d = 1'b0;
                    si_d    = READ;
                    read_d  = READ;
                    hdr_d   = {ADDR, 1'b0};
                    db_d    = WDATA;
                    take_d  = 1'b1;
                    left_d  = (BYTES == 8'h00) ? 8'h01 : BYTES;
                    cnt_d   = 5'h00;
                end
            end
            ST_RUN: begin
                if (tick && !sclk_q) begin
                    sclk_d = 1'b1;
                    cnt_d  = cnt_q + 5'h01;
                    if (cnt_q >= DATA_FIRST) begin
                        rx_d = {rx_q[6:0], so_s_q};
                        if (cnt_q[2:0] == BYTE_LAST) begin
                            cnt_d   = DATA_FIRST;
                            rdv_d   = read_q;
                            rdata_d = {rx_q[6:0], so_s_q};
                            left_d  = left_q - 8'h01;
                            if (left_q == 8'h01) begin
                                st_d = ST_STOP;
                            end else begin
                                db_d   = WDATA;
                                take_d = ~read_q;
                            end
                        end
                    end
                end else if (tick && sclk_q) begin
                    sclk_d = 1'b0;
                    if (cnt_q < DATA_FIRST) begin
                        si_d = hdr_q[15];
                        hdr_d = {hdr_q[14:0], 1'b0};
                    end else begin
                        si_d = db_q[7];
                        db_d  = {db_q[6:0], 1'b0};
                    end
                end
            end
            ST_STOP: begin
                if (tick) begin
                    sclk_d  = 1'b0;
                    if (!sclk_q) begin
                        sel_n_d = 1'b1;
                        st_d    = ST_GAP;
                    end
                end
            end
            ST_GAP: begin
                if (tick) begin
                    st_d = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            st_q    <= ST_IDLE;
            div_q   <= 4'h0;
            cnt_q   <= 5'h00;
            hdr_q   <= 16'h0000;
            db_q    <= 8'h00;
            rx_q    <= 8'h00;
            left_q  <= 8'h00;
            sclk_q  <= 1'b0;
            sel_n_q <= 1'b1;
            si_q    <= 1'b0;
            read_q  <= 1'b0;
            take_q  <= 1'b0;
            rdv_q   <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            st_q    <= st_d;
            div_q   <= div_d;
            cnt_q   <= cnt_d;
            hdr_q   <= hdr_d;
            db_q    <= db_d;
            rx_q    <= rx_d;
            left_q  <= left_d;
            sclk_q  <= sclk_d;
            sel_n_q <= sel_n_d;
            si_q    <= si_d;
            read_q  <= read_d;
            take_q  <= take_d;
            rdv_q   <= rdv_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign LINK.sclk      = sclk_q;
    assign LINK.select_n  = sel_n_q;
    assign LINK.serial_in = si_q;
    assign BUSY           = (st_q != ST_IDLE);
    assign WDATA_TAKEN    = take_q;
    assign RDATA          = rdata_q;
    assign RDATA_VALID    = rdv_q;

endmodule : sra_host

`default_nettype wire

//--- tb/sra_link_asserts.sv
`timescale 1ns/100ps
`default_nettype none

module sra_link_asserts (
    input wire logic CLK_SYS,
    input wire logic RESET,
    input wire logic sclk,
    input wire logic select_n,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_oe
);
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (RESET);

    // ------------------------------------------------------------------
    // Frame tracking
    // ------------------------------------------------------------------
    logic       sclk_q;
    logic [7:0] rise_cnt_q;
    logic [7:0] rise_cnt_d;
    logic       is_read_q;
    logic       is_read_d;

    always_comb begin
        rise_cnt_d = rise_cnt_q;
        is_read_d  = is_read_q;
        if (select_n) begin
            rise_cnt_d = 8'h00;
        end else if (sclk && !sclk_q) begin
            rise_cnt_d = rise_cnt_q + 8'h01;
            if (rise_cnt_q == 8'h00) begin
                is_read_d = serial_in;
            end
        end
    end

    always_ff @(posedge CLK_SYS or posedge RESET) begin
        if (RESET) begin
            sclk_q     <= 1'b0;
            rise_cnt_q <= 8'h00;
            is_read_q  <= 1'b0;
        end else begin
            sclk_q     <= sclk;
            rise_cnt_q <= rise_cnt_d;
            is_read_q  <= is_read_d;
        end
    end

    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_sel_frame;
        $rose(select_n) |-> (rise_cnt_q >= 8'd24 && rise_cnt_q[2:0] == 3'h0);
    endproperty
    a_sel_frame: assert property (p_sel_frame)
        else $error("select released inside a byte");
    property p_sclk_high;
        $rose(sclk) |-> sclk [*8];
    endproperty
    a_sclk_high: assert property (p_sclk_high)
        else $error("serial clock high phase too short");
    property p_sclk_low;
        ($fell(sclk) && !select_n) |-> !sclk [*8];
    endproperty
    a_sclk_low: assert property (p_sclk_low)
        else $error("serial clock low phase too short");
    property p_sel_sclk_low;
        $changed(select_n) |-> !sclk;
    endproperty
    a_sel_sclk_low: assert property (p_sel_sclk_low)
        else $error("select moved while serial clock high");
    property p_in_stable;
        (sclk && $past(sclk)) |-> $stable(serial_in);
    endproperty
    a_in_stable: assert property (p_in_stable)
        else $error("serial input moved while clock high");
    property p_hdr_off;
        (rise_cnt_q != 8'h00 && rise_cnt_q < 8'd16) |-> !serial_out_oe;
    endproperty
    a_hdr_off: assert property (p_hdr_off)
        else $error("output driven during header");
    property p_wr_off;
        (rise_cnt_q != 8'h00 && !is_read_q) |-> !serial_out_oe;
    endproperty
    a_wr_off: assert property (p_wr_off)
        else $error("output driven during write frame");
    property p_rd_on;
        (is_read_q && rise_cnt_q >= 8'd17 && !select_n) |-> serial_out_oe;
    endproperty
    a_rd_on: assert property (p_rd_on)
        else $error("output not driven in read data phase");
    property p_rel_off;
        $rose(select_n) |-> ##[0:6] !serial_out_oe;
    endproperty
    a_rel_off: assert property (p_rel_off)
        else $error("output still driven after select release");
    property p_out_stable;
        (serial_out_oe && sclk && $past(sclk)) |-> $stable(serial_out);
    endproperty
    a_out_stable: assert property (p_out_stable)
        else $error("read data moved while clock high");

    c_read: cover property (is_read_q && rise_cnt_q == 8'd24);
    c_write: cover property (!is_read_q && rise_cnt_q == 8'd24);
    c_stream: cover property (rise_cnt_q == 8'd40);
endmodule : sra_link_asserts

`default_nettype wire

//--- tb/serial_register_access_port_bench.sv
`timescale 1ns/100ps
`default_nettype none

module serial_register_access_port_bench
    import sra_pkg::*;
;
    // Identity values are arbitrary.
    localparam logic [7:0]  PC = 8'hC3;
    localparam logic [15:0] PI = 16'h7E81;
    localparam logic [7:0]  SR = 8'h2D;
    localparam logic [15:0] MI = 16'h6B94;

    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic        rd = 1'b0;
    logic [14:0] addr = 15'h0000;
    logic [7:0]  wdata = 8'h00;
    logic [7:0]  nbytes = 8'h00;
    logic        cal_busy = 1'b0;
    logic        busy;
    logic        taken;
    logic [7:0]  rdata;
    logic        rvalid;
    logic [7:0]  oper;
    logic [7:0]  iface;
    logic        active;
    logic [7:0]  oper_b;
    logic [7:0]  wq [$] = '{8'h00};
    logic [7:0]  rq [$];
    logic [7:0]  eq [$];
    int          bad_count = 0;
    int          num_checks = 0;

    always #20 clk = ~clk;

    sra_if sra_if_inst ();
    sra_if sra_if_inst_b ();

    sra_device #(.PART_CLASS_VAL(PC), .PART_ID_VAL(PI),
        .SILICON_REV_VAL(SR), .MAKER_ID_VAL(MI)) sra_device_inst (
        .CLK_SYS(clk), .RESET(rst), .LINK(sra_if_inst),
        .OPERATING_SETUP(oper), .INTERFACE_SETUP(iface),
        .ACCESS_ACTIVE(active));
    sra_device sra_device_inst_b (
        .CLK_SYS(clk), .RESET(rst), .LINK(sra_if_inst_b),
        .OPERATING_SETUP(oper_b), .INTERFACE_SETUP(), .ACCESS_ACTIVE());
    sra_host sra_host_inst (
        .CLK_SYS(clk), .RESET(rst), .LINK(sra_if_inst), .START(start),
        .READ(rd), .ADDR(addr), .WDATA(wdata), .BYTES(nbytes),
        .CAL_BUSY(cal_busy), .BUSY(busy), .WDATA_TAKEN(taken),
        .RDATA(rdata), .RDATA_VALID(rvalid));
    sra_link_asserts sra_link_asserts_inst (
        .CLK_SYS(clk), .RESET(rst), .sclk(sra_if_inst.sclk),
        .select_n(sra_if_inst.select_n), .serial_in(sra_if_inst.serial_in),
        .serial_out(sra_if_inst.serial_out),
        .serial_out_oe(sra_if_inst.serial_out_oe));

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen,
                         input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : summarize

    // Starts one frame and follows it to its end, feeding and collecting.
    task automatic xfer(input logic r, input logic [14:0] a, input int n);
        int t;
        int wi;
        bit seen;
        wi = 0;
        seen = 0;
        rq.delete();
        @(posedge clk);
        start <= 1'b1;
        rd <= r;
        addr <= a;
        nbytes <= 8'(n);
        wdata <= wq[0];
        @(posedge clk);
        start <= 1'b0;
        for (t = 0; t < 3000; t++) begin
            @(posedge clk);
            if (taken === 1'b1 && wi + 1 < wq.size()) begin
                wi++;
                wdata <= wq[wi];
            end
            if (rvalid === 1'b1) begin
                rq.push_back(rdata);
            end
            if (t == 20) begin
                check("access active", 16'(active), 16'h0001);
            end
            if (busy === 1'b1) begin
                seen = 1;
            end else if (seen) begin
                break;
            end
        end
        if (t == 3000) bad_count++;
    endtask : xfer

    task automatic rd_cmp(input logic [14:0] a);
        int i;
        xfer(1'b1, a, eq.size());
        check("read count", 16'(rq.size()), 16'(eq.size()));
        for (i = 0; i < eq.size(); i++) begin
            check("read byte", 16'(rq[i]), 16'(eq[i]));
        end
    endtask : rd_cmp

    // Drives the second link by hand at a 320 ns serial clock.
    task automatic bang(input logic [23:0] f, input int n);
        int i;
        @(posedge clk);
        sra_if_inst_b.select_n <= 1'b0;
        for (i = 23; i > 23 - n; i--) begin
            sra_if_inst_b.serial_in <= f[i];
            repeat (4) @(posedge clk);
            sra_if_inst_b.sclk <= 1'b1;
            repeat (4) @(posedge clk);
            sra_if_inst_b.sclk <= 1'b0;
        end
        repeat (4) @(posedge clk);
        sra_if_inst_b.select_n <= 1'b1;
        sra_if_inst_b.serial_in <= ~f[24 - n];
        repeat (16) @(posedge clk);
    endtask : bang

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        sra_if_inst_b.sclk = 1'b0;
        sra_if_inst_b.select_n = 1'b1;
        sra_if_inst_b.serial_in = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        eq = '{RST_IFACE_SETUP_A, 8'h00, RST_OPER_SETUP, PC, PI[7:0],
               PI[15:8], SR};
        rd_cmp(ADR_IFACE_SETUP_A);
        eq = '{MI[7:0], MI[15:8], 8'h00, 8'h00, RST_USER_SETUP, 8'h00};
        rd_cmp(ADR_MAKER_ID_LO);
        wq = '{8'hA5};
        xfer(1'b0, ADR_OPER_SETUP, 1);
        check("operating_setup", 16'(oper), 16'h00A5);
        wq = '{8'hFF};
        xfer(1'b0, ADR_PART_CLASS, 1);
        eq = '{8'hA5, PC};
        rd_cmp(ADR_OPER_SETUP);
        wq = '{8'h1C};
        xfer(1'b0, ADR_IFACE_SETUP_A, 1);
        check("interface_setup", 16'(iface), 16'h001C);
        wq = '{8'h3C, 8'h77, 8'h99};
        xfer(1'b0, ADR_OPER_SETUP, 3);
        check("descending write", 16'(iface), 16'h0099);
        eq = '{PC, 8'h3C};
        rd_cmp(ADR_PART_CLASS);
        wq = '{8'h30};
        xfer(1'b0, ADR_IFACE_SETUP_A, 1);
        wq = '{8'h01};
        xfer(1'b0, ADR_USER_SETUP, 1);
        wq = '{8'h11, 8'h22};
        xfer(1'b0, ADR_OPER_SETUP, 2);
        check("held write", 16'(oper), 16'h0022);
        eq = '{8'h22, 8'h22};
        rd_cmp(ADR_OPER_SETUP);
        wq = '{8'h00};
        xfer(1'b0, ADR_USER_SETUP, 1);
        eq = '{8'h22, PC};
        rd_cmp(ADR_OPER_SETUP);
        check("access idle", 16'(active), 16'h0000);
        @(posedge clk);
        cal_busy <= 1'b1;
        start <= 1'b1;
        repeat (10) @(posedge clk);
        check("start during calibration", 16'(busy), 16'h0000);
        start <= 1'b0;
        cal_busy <= 1'b0;
        repeat (4) @(posedge clk);
        bang({1'b0, ADR_OPER_SETUP, 8'h5A}, 23);
        check("aborted write", 16'(oper_b), 16'h0000);
        bang({1'b0, ADR_OPER_SETUP, 8'h5A}, 24);
        check("hand frame write", 16'(oper_b), 16'h005A);
        summarize();
    end

    initial begin
        #2000000;
        bad_count++;
        summarize();
    end
endmodule : serial_register_access_port_bench

`default_nettype wire
